/* File: logic/iswd_pkg.sv */
// ==================================================================
// Shared constants
package iswd_pkg;
   // Status word layout
   localparam int unsigned ISWD_W        = 16;
   localparam int unsigned BIT_ERR       = 15;
   localparam int unsigned BIT_TIMEOUT   = 14;
   localparam int unsigned BIT_END       = 13;
   localparam int unsigned BIT_BUS_SRV   = 12;
   localparam int unsigned BIT_DEV_SRV   = 11;
   localparam int unsigned BIT_RSVD_HI   = 10;
   localparam int unsigned BIT_RSVD_LO   = 9;
   localparam int unsigned BIT_IO_IO_COMPLETE_FLAG   = 8;
   localparam int unsigned BIT_LOCKOUT   = 7;
   localparam int unsigned BIT_REMOTE    = 6;
   localparam int unsigned BIT_CTRL      = 5;
   localparam int unsigned BIT_ATTN      = 4;
   localparam int unsigned BIT_TALKER    = 3;
   localparam int unsigned BIT_LISTENER  = 2;
   localparam int unsigned BIT_TRIGGER   = 1;
   localparam int unsigned BIT_DEV_CLEAR = 0;
   // Value after reset, and word returned when the board cannot be reached
   localparam logic [15:0] STATUS_RST    = 16'h0000;
   localparam logic [15:0] STATUS_NO_BRD = 16'h8000;
   // Serial poll byte bit that flags a service request
   localparam int unsigned SPOLL_RQS_BIT = 6;
endpackage

/* File: logic/iswd_flag.sv */
`timescale 1ns/10ps
// ==================================================================
// One sticky condition bit; a set in the same cycle as a clear wins
module iswd_flag (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_n_i,
   // Events
   input  wire logic set_i,
   input  wire logic clr_i,
   // State
   output logic      flag_o
);
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

/* File: logic/iswd_status.sv */
`timescale 1ns/10ps
// ==================================================================
// How it works
// - Sixteen-bit status word, fourteen meaningful bits, one means condition holds.
// - Error 15, timeout 14, end 13, bus service 12, device service 11, complete 8.
// - Lockout 7, remote 6, controller 5, attention 4, talk 3, listen 2, trigger 1, clear 0.
// - Device service only on device calls; bus-state bits only on board calls.
// - Error bit set after a failing call, cleared after a good one.
// - Timeout bit set on expired wait or transfer timeout, else cleared.
// - End bit set on end line or enabled end byte; cleared when I/O starts.
// - During shadow handshake any call may report an earlier end.
// - Bus service set when controller, request line up, auto poll off.
// - Device service set by poll byte bit 6; cleared by explicit poll.
// - Complete bit low while I/O runs, high once finished.
// - Lockout set on lockout message, cleared by remote enable release; blocks go-local.
// - Remote set when remote enable up and own listen address seen.
// - Remote cleared by enable release, go-to-local as listener, or unlocked local request.
// - Controller set by own interface clear as system controller, or control passed in.
// - Controller cleared by interface clear from system controller or passing control.
// - Attention bit follows the attention line.
// - Word refreshed after every call and returned as its result.
// - Talker set on own talk address; cleared on untalk, own listen, other talk, clear.
// - Listener set on own listen or shadow start; cleared on unlisten, talk, clear, plain release.
// - Unreachable board: every bit but error cleared.
module iswd_status
   import iswd_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   // Bus lines
   input  wire logic        atn_i,
   input  wire logic        srq_i,
   input  wire logic        ren_i,
   input  wire logic        ifc_i,
   // Decoded bus messages, one-cycle pulses
   input  wire logic        my_listen_i,
   input  wire logic        my_talk_i,
   input  wire logic        other_talk_i,
   input  wire logic        untalk_i,
   input  wire logic        unlisten_i,
   input  wire logic        lockout_msg_i,
   input  wire logic        go_local_msg_i,
   input  wire logic        trigger_msg_i,
   input  wire logic        dev_clear_msg_i,
   input  wire logic        sel_clear_msg_i,
   input  wire logic        take_ctrl_i,
   input  wire logic        end_msg_i,
   input  wire logic        eos_byte_i,
   // Board state and actions
   input  wire logic        sys_ctrl_i,
   input  wire logic        auto_poll_en_i,
   input  wire logic        eos_term_en_i,
   input  wire logic        send_interface_clear_routine_i,
   input  wire logic        pass_ctrl_i,
   input  wire logic        go_local_request_routine_i,
   input  wire logic        shadow_start_i,
   input  wire logic        release_plain_i,
   input  wire logic        io_start_i,
   input  wire logic        io_busy_i,
   input  wire logic        trig_ack_i,
   input  wire logic        clear_ack_i,
   // Serial poll result
   input  wire logic        spoll_done_i,
   input  wire logic        spoll_explicit_i,
   input  wire logic [7:0]  spoll_byte_i,
   // Call completion
   input  wire logic        call_done_i,
   input  wire logic        call_board_i,
   input  wire logic        call_error_i,
   input  wire logic        call_no_board_i,
   input  wire logic        call_timeout_i,
   // Status word
   output logic [15:0]      interface_status_word_o,
   output logic             status_valid_o
);
   // ===============================================================
   // Condition flags
   logic lockout_flag;
   logic remote_state_flag;
   logic controller_in_charge_flag;
   logic talker_addressed_flag;
   logic listener_addressed_flag;
   logic device_trigger_flag;
   logic device_clear_flag;
   logic end_flag;
   logic device_service_request_flag;
   logic bus_service_interrupt_flag;
   logic io_complete_flag;
   logic timeout_flag;
   logic error_flag;
   logic [15:0] next_word;

   // Hard to stay locked once remote enable is gone
   iswd_flag u_lockout (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (lockout_msg_i),
      .clr_i     (!ren_i),
      .flag_o    (lockout_flag)
   );

   iswd_flag u_remote (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (ren_i && my_listen_i),
      .clr_i     (!ren_i || (go_local_msg_i && listener_addressed_flag)
                  || (go_local_request_routine_i && !lockout_flag)),
      .flag_o    (remote_state_flag)
   );

   // Our own interface clear also shows on the line; the set wins over it
   iswd_flag u_ctrl (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     ((send_interface_clear_routine_i && sys_ctrl_i)
                  || take_ctrl_i),
      .clr_i     (ifc_i || pass_ctrl_i),
      .flag_o    (controller_in_charge_flag)
   );

   iswd_flag u_talker (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (my_talk_i),
      .clr_i     (untalk_i || my_listen_i || other_talk_i || ifc_i),
      .flag_o    (talker_addressed_flag)
   );

   iswd_flag u_listener (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (my_listen_i || shadow_start_i),
      .clr_i     (unlisten_i || my_talk_i || ifc_i || release_plain_i),
      .flag_o    (listener_addressed_flag)
   );

   iswd_flag u_trigger (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (trigger_msg_i && listener_addressed_flag),
      .clr_i     (trig_ack_i),
      .flag_o    (device_trigger_flag)
   );

   iswd_flag u_dev_clear (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (dev_clear_msg_i || (sel_clear_msg_i && listener_addressed_flag)),
      .clr_i     (clear_ack_i),
      .flag_o    (device_clear_flag)
   );

   // Sticky until the next I/O starts, so a shadow handshake end is seen later
   iswd_flag u_end (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (end_msg_i || (eos_term_en_i && eos_byte_i)),
      .clr_i     (io_start_i),
      .flag_o    (end_flag)
   );

   iswd_flag u_dev_srv (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (spoll_done_i && !spoll_explicit_i
                  && spoll_byte_i[SPOLL_RQS_BIT]),
      .clr_i     (spoll_done_i && spoll_explicit_i),
      .flag_o    (device_service_request_flag)
   );

   // ===============================================================
   // Live conditions
   always_comb begin
      bus_service_interrupt_flag = controller_in_charge_flag && srq_i
                                   && !auto_poll_en_i;
      io_complete_flag           = !io_busy_i;
      timeout_flag               = call_timeout_i;
      error_flag                 = call_error_i || call_no_board_i;
   end

   // ===============================================================
   // Word assembly
   always_comb begin
      next_word = STATUS_RST;
      if (call_no_board_i) begin
         next_word = STATUS_NO_BRD;
      end else begin
         next_word[BIT_ERR]     = error_flag;
         next_word[BIT_TIMEOUT] = timeout_flag;
         next_word[BIT_END]     = end_flag;
         next_word[BIT_IO_IO_COMPLETE_FLAG] = io_complete_flag;
         next_word[BIT_RSVD_HI] = 1'b0;
         next_word[BIT_RSVD_LO] = 1'b0;
         if (call_board_i) begin
            next_word[BIT_BUS_SRV]   = bus_service_interrupt_flag;
            next_word[BIT_LOCKOUT]   = lockout_flag;
            next_word[BIT_REMOTE]    = remote_state_flag;
            next_word[BIT_CTRL]      = controller_in_charge_flag;
            next_word[BIT_ATTN]      = atn_i;
            next_word[BIT_TALKER]    = talker_addressed_flag;
            next_word[BIT_LISTENER]  = listener_addressed_flag;
            next_word[BIT_TRIGGER]   = device_trigger_flag;
            next_word[BIT_DEV_CLEAR] = device_clear_flag;
         end else begin
            next_word[BIT_DEV_SRV]   = device_service_request_flag;
         end
      end
   end

   // ===============================================================
   // Word register, refreshed once per call
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         interface_status_word_o <= STATUS_RST;
      end else if (call_done_i) begin
         interface_status_word_o <= next_word;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_valid_o <= 1'b0;
      end else begin
         status_valid_o <= call_done_i;
      end
   end

   // ===============================================================
   // Checks
   a_err_after_call: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i |=> interface_status_word_o[BIT_ERR]
         == ($past(call_error_i) || $past(call_no_board_i)))
      else $error("error bit does not match call outcome");

   a_no_board_word: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i && call_no_board_i |=> interface_status_word_o == STATUS_NO_BRD)
      else $error("unreachable board word wrong");

   a_timeout_bit: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i && !call_no_board_i
      |=> interface_status_word_o[BIT_TIMEOUT] == $past(call_timeout_i))
      else $error("timeout bit wrong");

   a_attn_tracks: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i && call_board_i && !call_no_board_i
      |=> interface_status_word_o[BIT_ATTN] == $past(atn_i))
      else $error("attention bit does not follow line");

   a_device_hides: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i && !call_board_i
      |=> interface_status_word_o[7:0] == 8'h00 && !interface_status_word_o[BIT_BUS_SRV])
      else $error("board bits leak into device word");

   a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      interface_status_word_o[10:9] == 2'b00)
      else $error("reserved bits not zero");

   a_lockout_drop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !ren_i && !lockout_msg_i |=> !lockout_flag)
      else $error("lockout held after remote enable release");

   a_remote_set: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      ren_i && my_listen_i |=> remote_state_flag)
      else $error("remote not set on own listen address");

   a_local_locked: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      remote_state_flag && lockout_flag && ren_i && go_local_request_routine_i
      && !go_local_msg_i |=> remote_state_flag)
      else $error("local request honoured under lockout");

   a_ctrl_take: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      take_ctrl_i || (send_interface_clear_routine_i && sys_ctrl_i)
      |=> controller_in_charge_flag)
      else $error("controller not taken");

   a_ctrl_pass: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      pass_ctrl_i && !take_ctrl_i && !send_interface_clear_routine_i
      |=> !controller_in_charge_flag)
      else $error("controller kept after passing");

   a_talk_drop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (untalk_i || other_talk_i || ifc_i) && !my_talk_i |=> !talker_addressed_flag)
      else $error("talker kept after untalk");

   a_listen_set: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      my_listen_i || shadow_start_i |=> listener_addressed_flag)
      else $error("listener not set");

   a_end_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      io_start_i && !end_msg_i && !eos_byte_i |=> !end_flag)
      else $error("end bit survives I/O start");

   a_io_complete_flag_busy: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i && !call_no_board_i
      |=> interface_status_word_o[BIT_IO_IO_COMPLETE_FLAG] == !$past(io_busy_i))
      else $error("complete bit wrong");

   a_srv_request: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i && call_board_i && !call_no_board_i
      |=> interface_status_word_o[BIT_BUS_SRV] == $past(bus_service_interrupt_flag))
      else $error("bus service bit wrong");

   a_poll_clears: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      spoll_done_i && spoll_explicit_i |=> !device_service_request_flag)
      else $error("explicit poll left service request");

   a_lockout_set: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      lockout_msg_i |=> lockout_flag)
      else $error("lockout not set by lockout message");

   a_remote_drop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !ren_i |=> !remote_state_flag)
      else $error("remote kept without remote enable");

   a_talk_set: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      my_talk_i |=> talker_addressed_flag)
      else $error("talker not set on own talk address");

   a_listen_drop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (unlisten_i || my_talk_i || ifc_i || release_plain_i) && !my_listen_i && !shadow_start_i
      |=> !listener_addressed_flag)
      else $error("listener kept after unlisten");

   a_end_set: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      end_msg_i || (eos_term_en_i && eos_byte_i) |=> end_flag)
      else $error("end bit not set by end condition");

   a_poll_sets: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      spoll_done_i && !spoll_explicit_i && spoll_byte_i[SPOLL_RQS_BIT]
      |=> device_service_request_flag)
      else $error("service request not taken from poll");

   a_dev_srv_bit: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i && !call_board_i && !call_no_board_i
      |=> interface_status_word_o[BIT_DEV_SRV] == $past(device_service_request_flag))
      else $error("device service bit wrong");

   a_ctrl_ifc: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      ifc_i && !take_ctrl_i && !(send_interface_clear_routine_i && sys_ctrl_i)
      |=> !controller_in_charge_flag)
      else $error("controller kept after interface clear");

   a_srv_drop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i && call_board_i && !call_no_board_i && !(controller_in_charge_flag && srq_i)
      |=> !interface_status_word_o[BIT_BUS_SRV])
      else $error("bus service bit set without request");

   a_valid_pulse: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      call_done_i |=> status_valid_o)
      else $error("no valid pulse after call");

   a_word_holds: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !call_done_i |=> $stable(interface_status_word_o))
      else $error("status word changed without a call");
endmodule

/* File: verif/iswd_bus_model.sv */
`timescale 1ns/10ps
// ==================================================
// Bus side: lines and decoded messages seen by the board
module iswd_bus_model (
   // Clock
   input  wire logic        sys_clk_i,
   // Lines: attention, service request, remote enable, interface clear
   output logic [3:0]       lines_o,
   // One-cycle message pulses
   output logic [12:0]      msg_o
);
   initial begin
      lines_o = 4'h0;
      msg_o   = 13'h0000;
   end
   // Levels stay put until changed; a pulse of ifc needs two calls
   task automatic ln(input logic [3:0] v);
      @(posedge sys_clk_i);
      lines_o <= v;
   endtask
   // A message lasts one cycle; the bus never repeats it unasked
   task automatic ms(input int i);
      @(posedge sys_clk_i);
      msg_o <= 13'h0001 << i;
      @(posedge sys_clk_i);
      msg_o <= 13'h0000;
   endtask
endmodule

/* File: verif/ieee488_interface_status_word_tb.sv */
`timescale 1ns/10ps
module ieee488_interface_status_word_tb;
   import iswd_pkg::*;
   logic        sys_clk;
   logic        reset_n;
   logic [3:0]  lines;
   logic [12:0] msg;
   logic [7:0]  hp;
   logic [3:0]  lv;
   logic        sp_done;
   logic        sp_expl;
   logic [7:0]  sp_byte;
   logic        cd;
   logic        cb;
   logic [2:0]  cf;
   logic [15:0] word;
   logic        valid;
   int          n_errors;
   int          cmp_count;
   int          cyc;
   // One net per design input, so every input follows its own stimulus
   logic        atn;
   logic        srq;
   logic        ren;
   logic        ifc;
   logic        my_listen;
   logic        my_talk;
   logic        other_talk;
   logic        untalk;
   logic        unlisten;
   logic        lockout_msg;
   logic        go_local_msg;
   logic        trigger_msg;
   logic        dev_clear_msg;
   logic        sel_clear_msg;
   logic        take_ctrl;
   logic        end_msg;
   logic        eos_byte;
   logic        sys_ctrl;
   logic        auto_poll_en;
   logic        eos_term_en;
   logic        io_busy;
   logic        send_interface_clear_routine;
   logic        pass_ctrl;
   logic        go_local_request_routine;
   logic        shadow_start;
   logic        release_plain;
   logic        io_start;
   logic        trig_ack;
   logic        clear_ack;
   logic        call_error;
   logic        call_no_board;
   logic        call_timeout;

   assign {atn, srq, ren, ifc} = lines;
   assign {eos_byte, end_msg, take_ctrl, sel_clear_msg, dev_clear_msg, trigger_msg,
           go_local_msg, lockout_msg, unlisten, untalk, other_talk, my_talk, my_listen} = msg;
   assign {sys_ctrl, auto_poll_en, eos_term_en, io_busy} = lv;
   assign {clear_ack, trig_ack, io_start, release_plain, shadow_start,
           go_local_request_routine, pass_ctrl, send_interface_clear_routine} = hp;
   assign {call_error, call_no_board, call_timeout} = cf;

   iswd_bus_model bus_u (.sys_clk_i(sys_clk), .lines_o(lines), .msg_o(msg));

   iswd_status dut_u (
      .sys_clk_i(sys_clk), .reset_n_i(reset_n),
      .atn_i(atn), .srq_i(srq), .ren_i(ren), .ifc_i(ifc),
      .my_listen_i(my_listen), .my_talk_i(my_talk), .other_talk_i(other_talk),
      .untalk_i(untalk), .unlisten_i(unlisten), .lockout_msg_i(lockout_msg),
      .go_local_msg_i(go_local_msg), .trigger_msg_i(trigger_msg),
      .dev_clear_msg_i(dev_clear_msg), .sel_clear_msg_i(sel_clear_msg),
      .take_ctrl_i(take_ctrl), .end_msg_i(end_msg), .eos_byte_i(eos_byte),
      .sys_ctrl_i(sys_ctrl), .auto_poll_en_i(auto_poll_en), .eos_term_en_i(eos_term_en),
      .io_busy_i(io_busy), .send_interface_clear_routine_i(send_interface_clear_routine),
      .pass_ctrl_i(pass_ctrl), .go_local_request_routine_i(go_local_request_routine),
      .shadow_start_i(shadow_start), .release_plain_i(release_plain), .io_start_i(io_start),
      .trig_ack_i(trig_ack), .clear_ack_i(clear_ack), .spoll_done_i(sp_done),
      .spoll_explicit_i(sp_expl), .spoll_byte_i(sp_byte), .call_done_i(cd), .call_board_i(cb),
      .call_error_i(call_error), .call_no_board_i(call_no_board), .call_timeout_i(call_timeout),
      .interface_status_word_o(word), .status_valid_o(valid)
   );

   always #5 sys_clk = ~sys_clk;

   // ==================================================
   // Tasks
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hpul(input int i);
      @(posedge sys_clk);
      hp <= 8'h01 << i;
      @(posedge sys_clk);
      hp <= 8'h00;
   endtask
   task automatic lvl(input logic [3:0] v);
      @(posedge sys_clk);
      lv <= v;
   endtask
   task automatic poll(input logic expl, input logic [7:0] b);
      @(posedge sys_clk);
      sp_done <= 1'b1;
      sp_expl <= expl;
      sp_byte <= b;
      @(posedge sys_clk);
      sp_done <= 1'b0;
   endtask
   // Flags: error, no board, timeout; word lands one edge after the request
   task automatic call(input logic b, input logic [2:0] f, input logic [15:0] exp);
      @(posedge sys_clk);
      cd <= 1'b1;
      cb <= b;
      cf <= f;
      @(posedge sys_clk);
      cd <= 1'b0;
      #1;
      check("valid", {15'h0000, valid}, 16'h0001);
      check("status word", word, exp);
   endtask
   task automatic bc(input logic [15:0] exp);
      call(1'b1, 3'b000, exp);
   endtask
   task automatic dc(input logic [15:0] exp);
      call(1'b0, 3'b000, exp);
   endtask

   // ==================================================
   // Hang guard, far above the roughly 180 cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         give_verdict;
      end
   end

   // ==================================================
   // Tests
   initial begin
      sys_clk = 1'b0;
      reset_n = 1'b0;
      {hp, lv, sp_done, sp_expl, sp_byte, cd, cb, cf} = '0;
      n_errors = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      bc(16'h0100);
      call(1'b1, 3'b101, 16'hC100);
      bc(16'h0100);
      bus_u.ln(4'b1000);
      bc(16'h0110);
      dc(16'h0100);
      bus_u.ln(4'b0000);
      bc(16'h0100);
      $display("test basic done");
      bus_u.ms(0);
      bc(16'h0104);
      bus_u.ms(7);
      bc(16'h0106);
      bus_u.ms(8);
      bc(16'h0107);
      hpul(6);
      bc(16'h0105);
      hpul(7);
      bus_u.ms(9);
      bc(16'h0105);
      hpul(7);
      bus_u.ms(1);
      bc(16'h0108);
      bus_u.ms(2);
      bc(16'h0100);
      bus_u.ms(1);
      bus_u.ms(3);
      bc(16'h0100);
      bus_u.ms(0);
      bus_u.ms(4);
      bus_u.ms(7);
      bc(16'h0100);
      hpul(3);
      bus_u.ms(11);
      bc(16'h2104);
      hpul(4);
      bc(16'h2100);
      $display("test addressing done");
      hpul(5);
      bc(16'h0100);
      lvl(4'b0010);
      bus_u.ms(12);
      dc(16'h2100);
      hpul(5);
      lvl(4'b0000);
      bus_u.ms(12);
      bc(16'h0100);
      lvl(4'b0001);
      bc(16'h0000);
      lvl(4'b0000);
      $display("test end done");
      bus_u.ln(4'b0010);
      bus_u.ms(0);
      bc(16'h0144);
      bus_u.ms(5);
      hpul(2);
      bc(16'h01C4);
      bus_u.ln(4'b0000);
      bc(16'h0104);
      bus_u.ln(4'b0010);
      bus_u.ms(0);
      bus_u.ms(6);
      bc(16'h0104);
      bus_u.ms(0);
      hpul(2);
      bc(16'h0104);
      $display("test remote done");
      hpul(0);
      bc(16'h0104);
      lvl(4'b1000);
      hpul(0);
      bc(16'h0124);
      bus_u.ln(4'b0110);
      bc(16'h1124);
      bus_u.ln(4'b0010);
      bc(16'h0124);
      lvl(4'b1100);
      bus_u.ln(4'b0110);
      bc(16'h0124);
      bus_u.ln(4'b0010);
      hpul(1);
      bc(16'h0104);
      bus_u.ms(10);
      bc(16'h0124);
      bus_u.ln(4'b0011);
      bus_u.ln(4'b0010);
      bc(16'h0100);
      $display("test controller done");
      poll(1'b0, 8'h40);
      dc(16'h0900);
      bc(16'h0100);
      poll(1'b1, 8'h40);
      dc(16'h0100);
      poll(1'b0, 8'hBF);
      dc(16'h0100);
      bus_u.ln(4'b1010);
      call(1'b1, 3'b110, 16'h8000);
      $display("test service done");
      give_verdict;
   end
endmodule
